/* design/pcr_regs.sv */
// Functional notes
// RULE_01 - eeprom data: software write, read-cycle load, zero reset
// RULE_02 - capability id always reads 10h
// RULE_03 - next pointer always reads zero
// RULE_04 - capability version always reads 0010b
// RULE_05 - port type 0101b upstream, 0110b downstream
// RULE_06 - slot present from strap, override allowed
// RULE_07 - interrupt message number reads zero
// RULE_08 - payload capability from strap, override allowed
// RULE_09 - phantom function field reads 00b
// RULE_10 - extended tag bit reads zero
// RULE_11 - both latency fields read 000b
// RULE_12 - role error bit resets one, override allowed
// RULE_13 - upstream captures slot power value
// RULE_14 - upstream captures slot power scale
// RULE_15 - start bit launches read or write cycle
// RULE_16 - reserved and read-only bits ignore writes
module pcr_regs (
   // clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // straps and port role
   input  wire logic        is_upstream,
   input  wire logic        slot_present_strap,
   input  wire logic        large_payload_strap,
   // smbus / eeprom autoload override
   input  wire logic        ovr_wr,
   input  wire logic        ovr_slot_present,
   input  wire logic [2:0]  ovr_payload_cap,
   input  wire logic        ovr_role_err,
   // set slot power limit message
   input  wire logic        spl_msg_valid,
   input  wire logic [7:0]  spl_value,
   input  wire logic [1:0]  spl_scale,
   // configuration access
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [31:0] cfg_wdata,
   input  wire logic [3:0]  cfg_be,
   output logic      [31:0] cfg_rdata,
   output logic             cfg_rd_valid,
   // eeprom cycle engine
   output logic             ee_start,
   output logic             ee_cmd_write,
   output logic      [15:0] ee_wdata,
   input  wire logic        ee_rd_done,
   input  wire logic [15:0] ee_rd_data
);

   // ****************************************
   // state
   // ****************************************
   pcr_pkg::pcr_state_e state, next_state;          // init sequencer
   logic        port_up, next_port_up;              // captured port role
   logic        slot_present, next_slot_present;    // slot present bit
   logic [2:0]  payload_cap, next_payload_cap;      // max payload supported
   logic        role_err, next_role_err;            // role based error bit
   logic [7:0]  spl_val, next_spl_val;              // captured power value
   logic [1:0]  spl_scl, next_spl_scl;              // captured power scale
   logic [15:0] ee_data, next_ee_data;              // eeprom data word
   logic        next_ee_start;                      // launch pulse
   logic        next_ee_cmd_write;                  // launch direction
   logic [31:0] next_cfg_rdata;                     // read answer
   logic        next_cfg_rd_valid;                  // read answer strobe
   logic [31:0] hdr_word;                           // assembled header
   logic [31:0] cap_word;                           // assembled capability word
   logic        ee_wr_hit;                          // write to eeprom word

   // ****************************************
   // read-only word assembly
   // ****************************************
   // constants and captured fields; reserved bits stay zero
   always_comb begin
      hdr_word = 32'h0000_0000;                                    // RULE_07 RULE_16
      hdr_word[7:0] = pcr_pkg::CAP_ID_VAL;                         // RULE_02
      hdr_word[15:8] = pcr_pkg::NEXT_PTR_VAL;                      // RULE_03
      hdr_word[pcr_pkg::HDR_VER_LSB +: 4] = pcr_pkg::CAP_VER_VAL;  // RULE_04
      hdr_word[pcr_pkg::HDR_TYPE_LSB +: 4] = port_up ?
         pcr_pkg::TYPE_UPSTREAM : pcr_pkg::TYPE_DOWNSTREAM;        // RULE_05
      hdr_word[pcr_pkg::HDR_SLOT_BIT] = slot_present;              // RULE_06
      cap_word = 32'h0000_0000;                                    // RULE_09 RULE_10 RULE_11
      cap_word[2:0] = payload_cap;                                 // RULE_08
      cap_word[pcr_pkg::CAP_ROLE_BIT] = role_err;                  // RULE_12
      cap_word[pcr_pkg::CAP_SPL_VAL_LSB +: 8] = spl_val;           // RULE_13
      cap_word[pcr_pkg::CAP_SPL_SCL_LSB +: 2] = spl_scl;           // RULE_14
   end

   // ****************************************
   // next-state logic
   // ****************************************
   // straps caught on first clock-enabled edge after reset release
   always_comb begin
      next_state        = state;
      next_port_up      = port_up;
      next_slot_present = slot_present;
      next_payload_cap  = payload_cap;
      next_role_err     = role_err;
      next_spl_val      = spl_val;
      next_spl_scl      = spl_scl;
      next_ee_data      = ee_data;
      next_ee_start     = 1'b0;
      next_ee_cmd_write = ee_cmd_write;
      next_cfg_rdata    = cfg_rdata;
      next_cfg_rd_valid = 1'b0;
      ee_wr_hit         = cfg_wr && (cfg_addr == pcr_pkg::OFF_EE_DATA);
      case (state)
         pcr_pkg::ST_INIT: begin
            // sample straps and port role once
            next_port_up      = is_upstream;                       // RULE_05
            next_slot_present = slot_present_strap;                // RULE_06
            next_payload_cap  = large_payload_strap ?
               pcr_pkg::PAYLOAD_512 : pcr_pkg::PAYLOAD_256;        // RULE_08
            next_state        = pcr_pkg::ST_RUN;
         end
         pcr_pkg::ST_RUN: begin
            // autoload / smbus override only; config writes ignored
            if (ovr_wr) begin
               next_slot_present = ovr_slot_present;               // RULE_06
               next_payload_cap  = ovr_payload_cap;                // RULE_08
               next_role_err     = ovr_role_err;                   // RULE_12
            end
            // power limit message, upstream port only
            if (spl_msg_valid && port_up) begin
               next_spl_val = spl_value;                           // RULE_13
               next_spl_scl = spl_scale;                           // RULE_14
            end
            // software data write per byte lane
            if (ee_wr_hit && cfg_be[2]) begin
               next_ee_data[7:0] = cfg_wdata[23:16];               // RULE_01
            end
            if (ee_wr_hit && cfg_be[3]) begin
               next_ee_data[15:8] = cfg_wdata[31:24];              // RULE_01
            end
            // read completion wins over a same-cycle write
            if (ee_rd_done) begin
               next_ee_data = ee_rd_data;                          // RULE_01
            end
            // start bit launches a cycle with the command bit
            if (ee_wr_hit && cfg_be[0] && cfg_wdata[pcr_pkg::EE_START_BIT]) begin
               next_ee_start     = 1'b1;                           // RULE_15
               next_ee_cmd_write = cfg_wdata[pcr_pkg::EE_CMD_BIT]; // RULE_15
            end
         end
         default: begin
            next_state = pcr_pkg::ST_INIT;
         end
      endcase
      // read decode; unmapped reads zero
      if (cfg_rd) begin
         next_cfg_rd_valid = 1'b1;
         case (cfg_addr)
            pcr_pkg::OFF_EE_DATA: next_cfg_rdata = {ee_data, 16'h0000};
            pcr_pkg::OFF_CAP_HDR: next_cfg_rdata = hdr_word;
            pcr_pkg::OFF_DEV_CAP: next_cfg_rdata = cap_word;
            default:              next_cfg_rdata = 32'h0000_0000;  // RULE_16
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   // clock enable freezes everything
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state        <= pcr_pkg::ST_INIT;
         port_up      <= 1'b1;
         slot_present <= 1'b0;
         payload_cap  <= pcr_pkg::PAYLOAD_256;
         role_err     <= pcr_pkg::ROLE_ERR_RST;
         spl_val      <= pcr_pkg::SPL_VAL_RST;
         spl_scl      <= pcr_pkg::SPL_SCL_RST;
         ee_data      <= pcr_pkg::EE_DATA_RST;
         ee_start     <= 1'b0;
         ee_cmd_write <= 1'b0;
         cfg_rdata    <= 32'h0000_0000;
         cfg_rd_valid <= 1'b0;
      end else if (clk_en) begin
         state        <= next_state;
         port_up      <= next_port_up;
         slot_present <= next_slot_present;
         payload_cap  <= next_payload_cap;
         role_err     <= next_role_err;
         spl_val      <= next_spl_val;
         spl_scl      <= next_spl_scl;
         ee_data      <= next_ee_data;
         ee_start     <= next_ee_start;
         ee_cmd_write <= next_ee_cmd_write;
         cfg_rdata    <= next_cfg_rdata;
         cfg_rd_valid <= next_cfg_rd_valid;
      end
   end

   // write data to the engine is the held data word
   assign ee_wdata = ee_data;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_hdr_constants: assert property ((clk_en && cfg_rd && cfg_addr == pcr_pkg::OFF_CAP_HDR)
      |=> cfg_rdata[19:0] == 20'h2_0010 && cfg_rdata[31:25] == 7'h00) // RULE_02
      else $error("header constant fields wrong");
   a_next_ptr_zero: assert property ((clk_en && cfg_rd && cfg_addr == pcr_pkg::OFF_CAP_HDR)
      |=> cfg_rdata[15:8] == 8'h00) // RULE_03
      else $error("next pointer not zero");
   a_port_type: assert property ((clk_en && cfg_rd && cfg_addr == pcr_pkg::OFF_CAP_HDR)
      |=> cfg_rdata[23:20] == ($past(port_up) ? 4'h5 : 4'h6)) // RULE_05
      else $error("port type wrong");
   a_strap_capture: assert property ((clk_en && state == pcr_pkg::ST_INIT)
      |=> slot_present == $past(slot_present_strap)
          && payload_cap == ($past(large_payload_strap) ? 3'h2 : 3'h1)) // RULE_08
      else $error("strap capture wrong");
   a_dev_cap_zero: assert property ((clk_en && cfg_rd && cfg_addr == pcr_pkg::OFF_DEV_CAP)
      |=> cfg_rdata[14:3] == 12'h000 && cfg_rdata[31:28] == 4'h0
          && cfg_rdata[17:16] == 2'h0) // RULE_11
      else $error("device capability constants wrong");
   a_spl_capture: assert property ((clk_en && state == pcr_pkg::ST_RUN && spl_msg_valid && port_up)
      |=> spl_val == $past(spl_value) && spl_scl == $past(spl_scale)) // RULE_13
      else $error("slot power not captured");
   a_spl_down_zero: assert property (!port_up && state == pcr_pkg::ST_RUN
      |-> spl_val == 8'h00 && spl_scl == 2'h0) // RULE_14
      else $error("slot power set on downstream port");
   a_ee_rd_load: assert property ((clk_en && state == pcr_pkg::ST_RUN && ee_rd_done)
      |=> ee_data == $past(ee_rd_data)) // RULE_01
      else $error("eeprom read data not loaded");
   a_ee_launch: assert property ((clk_en && state == pcr_pkg::ST_RUN && ee_wr_hit && cfg_be[0]
      && cfg_wdata[0]) |=> ee_start && ee_cmd_write == $past(cfg_wdata[1])) // RULE_15
      else $error("eeprom cycle not launched");
   a_ro_stable: assert property ((clk_en && state == pcr_pkg::ST_RUN && !ovr_wr)
      |=> $stable(payload_cap) && $stable(role_err) && $stable(slot_present)) // RULE_16
      else $error("read-only field changed");

   c_override:  cover property (clk_en && state == pcr_pkg::ST_RUN && ovr_wr);
   c_spl_msg:   cover property (clk_en && spl_msg_valid && port_up);
   c_ee_read:   cover property (ee_start && !ee_cmd_write ##[1:20] ee_rd_done);
   c_cap_read:  cover property (clk_en && cfg_rd && cfg_addr == pcr_pkg::OFF_DEV_CAP);

endmodule

/* shared/pcr_pkg.sv */
package pcr_pkg;
   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0]  OFF_EE_DATA      = 8'hbc;  // eeprom data word
   localparam logic [7:0]  OFF_CAP_HDR      = 8'hc0;  // express capability header
   localparam logic [7:0]  OFF_DEV_CAP      = 8'hc4;  // device capability word

   // ****************************************
   // field positions
   // ****************************************
   localparam int          EE_START_BIT     = 0;      // eeprom start in byte 0
   localparam int          EE_CMD_BIT       = 1;      // eeprom command in byte 0
   localparam int          EE_DATA_LSB      = 16;     // eeprom data 31:16
   localparam int          HDR_VER_LSB      = 16;     // capability version 19:16
   localparam int          HDR_TYPE_LSB     = 20;     // port type 23:20
   localparam int          HDR_SLOT_BIT     = 24;     // slot present
   localparam int          CAP_ROLE_BIT     = 15;     // role based error reporting
   localparam int          CAP_SPL_VAL_LSB  = 18;     // captured power value 25:18
   localparam int          CAP_SPL_SCL_LSB  = 26;     // captured power scale 27:26

   // ****************************************
   // constant field values and reset values
   // ****************************************
   localparam logic [7:0]  CAP_ID_VAL       = 8'h10;  // express capability id
   localparam logic [7:0]  NEXT_PTR_VAL     = 8'h00;  // end of capability list
   localparam logic [3:0]  CAP_VER_VAL      = 4'h2;   // version nibble 0010b
   localparam logic [3:0]  TYPE_UPSTREAM    = 4'h5;   // 0101b
   localparam logic [3:0]  TYPE_DOWNSTREAM  = 4'h6;   // 0110b
   localparam logic [2:0]  PAYLOAD_256      = 3'h1;   // 001b, strap low
   localparam logic [2:0]  PAYLOAD_512      = 3'h2;   // 010b, strap high
   localparam logic [15:0] EE_DATA_RST      = 16'h0000;
   localparam logic        ROLE_ERR_RST     = 1'b1;
   localparam logic [7:0]  SPL_VAL_RST      = 8'h00;
   localparam logic [1:0]  SPL_SCL_RST      = 2'h0;

   // ****************************************
   // init sequencing
   // ****************************************
   typedef enum logic [0:0] {
      ST_INIT = 1'b0,   // straps not yet sampled
      ST_RUN  = 1'b1    // normal operation
   } pcr_state_e;
endpackage

/* testbench/pcr_regs_tb.sv */
module pcr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        clk_en = 1'b1;              // dropped once per pass
   logic        is_upstream = 1'b1;
   logic        slot_present_strap = 1'b0;
   logic        large_payload_strap = 1'b0;
   logic        ovr_wr = 1'b0;
   logic        ovr_slot_present = 1'b0;
   logic [2:0]  ovr_payload_cap = 3'h0;
   logic        ovr_role_err = 1'b0;
   logic        spl_msg_valid = 1'b0;
   logic [7:0]  spl_value = 8'h00;
   logic [1:0]  spl_scale = 2'h0;
   logic        cfg_wr = 1'b0;
   logic        cfg_rd = 1'b0;
   logic [7:0]  cfg_addr = 8'h00;
   logic [31:0] cfg_wdata = 32'h0;
   logic [3:0]  cfg_be = 4'h0;
   logic [31:0] cfg_rdata;
   logic        cfg_rd_valid;
   logic        ee_start;
   logic        ee_cmd_write;
   logic [15:0] ee_wdata;
   logic        ee_rd_done = 1'b0;
   logic [15:0] ee_rd_data = 16'h0;
   int          errors = 0;
   int          num_checks = 0;
   // expected field state
   logic        up_m;
   logic        slot_m;
   logic [2:0]  pay_m;
   logic        role_m;
   logic [7:0]  val_m;
   logic [1:0]  scl_m;
   logic [15:0] d_m;
   logic [31:0] seed;

   pcr_regs dut (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .is_upstream(is_upstream),
      .slot_present_strap(slot_present_strap), .large_payload_strap(large_payload_strap),
      .ovr_wr(ovr_wr), .ovr_slot_present(ovr_slot_present),
      .ovr_payload_cap(ovr_payload_cap), .ovr_role_err(ovr_role_err),
      .spl_msg_valid(spl_msg_valid), .spl_value(spl_value), .spl_scale(spl_scale),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_be(cfg_be), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
      .ee_start(ee_start), .ee_cmd_write(ee_cmd_write), .ee_wdata(ee_wdata),
      .ee_rd_done(ee_rd_done), .ee_rd_data(ee_rd_data)
   );

   // ****************************************
   // clock, watchdog, helpers
   // ****************************************
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   // cuts a hang short
   initial begin
      #100000;
      errors++;
      print_verdict();
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // one write strobe, returns just after the taking edge
   task automatic cfg_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_be <= be;
      @(posedge ref_clk);
      cfg_wr <= 1'b0;
      #1;
   endtask

   // one read strobe, answer checked a cycle later
   task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge ref_clk);
      cfg_rd <= 1'b0;
      #1;
      check("cfg_rd_valid", {31'h0, cfg_rd_valid}, 32'h1);
      check("cfg_rdata", cfg_rdata, exp);
   endtask

   function automatic logic [31:0] exp_hdr();
      return {7'h0, slot_m, up_m ? pcr_pkg::TYPE_UPSTREAM : pcr_pkg::TYPE_DOWNSTREAM,
              pcr_pkg::CAP_VER_VAL, pcr_pkg::NEXT_PTR_VAL, pcr_pkg::CAP_ID_VAL};
   endfunction

   function automatic logic [31:0] exp_cap();
      return {4'h0, scl_m, val_m, 2'h0, role_m, 12'h000, pay_m};
   endfunction

   // ****************************************
   // main sequence, once per port role
   // ****************************************
   initial begin
      seed = $urandom(32'hee0e);
      for (int r = 0; r < 2; r++) begin
         up_m = (r == 0);
         slot_m = 1'($urandom);
         pay_m = 1'($urandom) ? pcr_pkg::PAYLOAD_512 : pcr_pkg::PAYLOAD_256;
         role_m = pcr_pkg::ROLE_ERR_RST;
         val_m = pcr_pkg::SPL_VAL_RST;
         scl_m = pcr_pkg::SPL_SCL_RST;
         d_m = pcr_pkg::EE_DATA_RST;
         rst <= 1'b1;
         is_upstream <= up_m;
         slot_present_strap <= slot_m;
         large_payload_strap <= (pay_m == pcr_pkg::PAYLOAD_512);
         repeat (12) @(posedge ref_clk);
         rst <= 1'b0;
         repeat (2) @(posedge ref_clk);
         cfg_read(pcr_pkg::OFF_CAP_HDR, exp_hdr());
         cfg_read(pcr_pkg::OFF_DEV_CAP, exp_cap());
         cfg_read(pcr_pkg::OFF_EE_DATA, {d_m, 16'h0});
         cfg_write(pcr_pkg::OFF_CAP_HDR, 32'hffff_ffff, 4'hf);
         cfg_write(pcr_pkg::OFF_DEV_CAP, 32'hffff_ffff, 4'hf);
         cfg_read(pcr_pkg::OFF_CAP_HDR, exp_hdr());
         cfg_read(pcr_pkg::OFF_DEV_CAP, exp_cap());
         cfg_read(8'hc8, 32'h0);
         repeat (3) begin
            // slot power message, then override strobe
            @(posedge ref_clk);
            spl_msg_valid <= 1'b1;
            spl_value <= 8'($urandom);
            spl_scale <= 2'($urandom);
            @(posedge ref_clk);
            spl_msg_valid <= 1'b0;
            if (up_m) val_m = spl_value;
            if (up_m) scl_m = spl_scale;
            cfg_read(pcr_pkg::OFF_DEV_CAP, exp_cap());
            @(posedge ref_clk);
            ovr_wr <= 1'b1;
            ovr_slot_present <= 1'($urandom);
            ovr_payload_cap <= 3'($urandom);
            ovr_role_err <= 1'($urandom);
            @(posedge ref_clk);
            ovr_wr <= 1'b0;
            slot_m = ovr_slot_present;
            pay_m = ovr_payload_cap;
            role_m = ovr_role_err;
            cfg_read(pcr_pkg::OFF_CAP_HDR, exp_hdr());
            cfg_read(pcr_pkg::OFF_DEV_CAP, exp_cap());
         end
         // data bytes only, start bit clear: no launch
         d_m = 16'($urandom);
         cfg_write(pcr_pkg::OFF_EE_DATA, {d_m, 16'hfffe}, 4'hc);
         check("ee_start", {31'h0, ee_start}, 32'h0);
         cfg_read(pcr_pkg::OFF_EE_DATA, {d_m, 16'h0});
         check("ee_wdata", {16'h0, ee_wdata}, {16'h0, d_m});
         // write launch, then read launch with data bytes disabled
         d_m = 16'($urandom);
         cfg_write(pcr_pkg::OFF_EE_DATA, {d_m, 16'h0003}, 4'hf);
         check("ee_start", {31'h0, ee_start}, 32'h1);
         check("ee_cmd_write", {31'h0, ee_cmd_write}, 32'h1);
         check("ee_wdata", {16'h0, ee_wdata}, {16'h0, d_m});
         cfg_write(pcr_pkg::OFF_EE_DATA, {~d_m, 16'h0001}, 4'h1);
         check("ee_start", {31'h0, ee_start}, 32'h1);
         check("ee_cmd_write", {31'h0, ee_cmd_write}, 32'h0);
         @(posedge ref_clk);
         #1;
         check("ee_start", {31'h0, ee_start}, 32'h0);
         cfg_read(pcr_pkg::OFF_EE_DATA, {d_m, 16'h0});
         // read cycle completes with fresh data
         d_m = 16'($urandom);
         @(posedge ref_clk);
         ee_rd_done <= 1'b1;
         ee_rd_data <= d_m;
         @(posedge ref_clk);
         ee_rd_done <= 1'b0;
         ee_rd_data <= ~d_m;
         cfg_read(pcr_pkg::OFF_EE_DATA, {d_m, 16'h0});
         // clock enable low: a launching data write must leave no trace
         @(posedge ref_clk);
         clk_en <= 1'b0;
         cfg_write(pcr_pkg::OFF_EE_DATA, {~d_m, 16'h0003}, 4'hf);
         check("ee_start", {31'h0, ee_start}, 32'h0);
         @(posedge ref_clk);
         clk_en <= 1'b1;
         cfg_read(pcr_pkg::OFF_EE_DATA, {d_m, 16'h0});
         check("ee_start", {31'h0, ee_start}, 32'h0);
      end
      print_verdict();
   end
endmodule
